//--- testbench/sce_link_properties.sv
module sce_link_properties
    import sce_pkg::*;
#(
    parameter int BIT_CYC = 4
)(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic txd,
    input wire logic cts_n,
    input wire logic rts,
    input wire logic beeper_n_o,
    input wire logic beeper_n_oe,
    input wire logic beeper_n
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int FRAME = 10 * BIT_CYC;
    logic busy;
    int fcnt;
    int hi_cnt;
    logic start;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    // Start of a frame seen from idle line
    assign start = !busy && !txd;

    // Frame position tracker and beeper on-time counter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            fcnt <= 0;
            hi_cnt <= 0;
        end else begin
            busy <= busy ? (fcnt != FRAME - 1) : !txd;
            fcnt <= busy ? fcnt + 1 : 1;
            hi_cnt <= beeper_n_oe ? hi_cnt + 1 : 0;
        end
    end

    a_bit_stable: assert property (busy && (fcnt % BIT_CYC != 0)
        |-> $stable(txd)) else $error("txd moved inside a bit");
    a_start_low: assert property (busy && fcnt < BIT_CYC |-> !txd)
        else $error("start bit not low");
    a_stop_high: assert property (busy && fcnt >= 9 * BIT_CYC |-> txd)
        else $error("stop bit not high");
    a_start_after_cts: assert property (start && !$past(busy)
        |-> !$past(cts_n, 3)) else $error("frame began without cts");
    a_rts_before_start: assert property (start && !$past(busy)
        |-> $past(rts)) else $error("frame began without rts");
    a_hold_while_blocked: assert property ((!busy && cts_n)[*6]
        |=> txd) else $error("sent while cts held off");
    a_beep_wire_low: assert property (beeper_n_oe
        |-> !beeper_n_o && !beeper_n) else $error("beeper not pulled low");
    a_beep_half_max: assert property (hi_cnt <= BEEP_HALF_CYC)
        else $error("beeper low phase too long");

    c_frame: cover property (start);
    c_wait_cts: cover property (rts && cts_n);
    c_beep: cover property ($rose(beeper_n_oe));
endmodule

//--- testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sce_pkg::*;
    logic ref_clk, arst_n, supply_low, bar_edge_in, beep_req;
    logic motor_swing = 1'b0;
    logic repair_req, tx_valid, user_scan, user_aim, user_ready, spin;
    logic tx_ready, nv_we, ctrl_ready, nv_fault, laser_emitter;
    logic wdog_bite, motor_on, rts_seen, beep_seen, txd_seen;
    logic scan_line_frame, digitized_pattern;
    logic [7:0] tx_data, r;
    logic [1:0] nv_addr;
    logic [15:0] nv_wdata, nv_rdata;
    logic [15:0] nv_mem [4];
    int miscompares, samples_checked, n;
    int mc = 0;

    sce_link_if sce_link_if_i();
    sce_device #(.RESET_HOLD(20)) sce_device_i(.ref_clk(ref_clk),
        .arst_n(arst_n), .link(sce_link_if_i), .supply_low(supply_low),
        .motor_swing(motor_swing), .bar_edge_in(bar_edge_in),
        .beep_req(beep_req), .repair_req(repair_req), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .nv_wdata(nv_wdata),
        .nv_addr(nv_addr), .nv_we(nv_we), .nv_rdata(nv_rdata),
        .ctrl_ready(ctrl_ready), .nv_fault(nv_fault),
        .wdog_bite(wdog_bite), .motor_on(motor_on),
        .laser_emitter(laser_emitter),
        .scan_line_frame(scan_line_frame),
        .digitized_pattern(digitized_pattern));
    sce_host sce_host_i(.ref_clk(ref_clk), .arst_n(arst_n),
        .link(sce_link_if_i), .user_scan(user_scan), .user_aim(user_aim),
        .user_hs_en(1'b1), .user_ready(user_ready), .user_txd(1'b1),
        .rts_seen(rts_seen), .beep_seen(beep_seen), .txd_seen(txd_seen));
    sce_link_properties #(.BIT_CYC(4)) sce_link_properties_i(
        .ref_clk(ref_clk), .arst_n(arst_n), .txd(sce_link_if_i.txd),
        .cts_n(sce_link_if_i.cts_n), .rts(sce_link_if_i.rts),
        .beeper_n_o(sce_link_if_i.beeper_n_o),
        .beeper_n_oe(sce_link_if_i.beeper_n_oe),
        .beeper_n(sce_link_if_i.beeper_n));

    // Parameter store with same-cycle read
    assign nv_rdata = nv_mem[nv_addr];
    always @(posedge ref_clk) if (nv_we) nv_mem[nv_addr] <= nv_wdata;

    // Motor oscillation while spinning
    always @(posedge ref_clk) begin
        mc <= mc + 1;
        if (spin && mc % 50 == 0) motor_swing <= !motor_swing;
    end

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = !ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("miscompares=%0d samples_checked=%0d", miscompares,
            samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Offer one byte and hold it until taken
    task automatic push(input logic [7:0] d);
        @(posedge ref_clk) begin
            tx_data <= d;
            tx_valid <= 1'b1;
        end
        for (int i = 0; i < 500; i++) begin
            @(negedge ref_clk);
            if (tx_ready === 1'b1) break;
        end
        @(posedge ref_clk) tx_valid <= 1'b0;
    endtask

    // Collect one frame from the serial line, four cycles a bit
    task automatic recv(output logic [7:0] b);
        for (int i = 0; i < 2000 && sce_link_if_i.txd !== 1'b0; i++)
            @(negedge ref_clk);
        repeat (2) @(negedge ref_clk);
        chk(16'(sce_link_if_i.txd), 16'h0000);
        for (int i = 0; i < 8; i++) begin
            repeat (4) @(negedge ref_clk);
            b[i] = sce_link_if_i.txd;
        end
        repeat (4) @(negedge ref_clk);
        chk(16'(sce_link_if_i.txd), 16'h0001);
    endtask

    task automatic wait_ready();
        for (n = 0; n < 300 && ctrl_ready !== 1'b1; n++) @(posedge ref_clk);
    endtask

    task automatic count_beep(input logic lvl);
        for (n = 0; n < 25000 && sce_link_if_i.beeper_n === lvl; n++)
            @(negedge ref_clk);
    endtask

    initial begin
        #900us;
        miscompares++;
        finish_test();
    end

    // Main sequence
    initial begin
        {arst_n, supply_low, bar_edge_in, beep_req} = '0;
        {repair_req, tx_valid, user_scan, user_aim, spin, tx_data} = '0;
        user_ready = 1'b1;
        nv_mem = '{16'h0003, 16'h0001, 16'h0000, NV_CHECK_GOOD};
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk(16'(ctrl_ready), 16'h0000);
        wait_ready();
        chk(16'(ctrl_ready), 16'h0001);
        chk(16'(nv_fault), 16'h0000);
        chk(nv_mem[0], 16'h0003);
        fork
            begin
                push(8'hA5);
                push(8'h3C);
            end
            begin
                recv(r);
                chk(16'(r), 16'h00A5);
                recv(r);
                chk(16'(r), 16'h003C);
            end
        join
        chk(16'(wdog_bite), 16'h0000);
        @(posedge ref_clk) user_ready <= 1'b0;
        push(8'h5A);
        repeat (100) @(posedge ref_clk);
        chk(16'(sce_link_if_i.txd), 16'h0001);
        chk(16'(sce_link_if_i.rts), 16'h0001);
        chk(16'(rts_seen), 16'h0001);
        chk(16'(txd_seen), 16'h0001);
        @(posedge ref_clk) user_ready <= 1'b1;
        recv(r);
        chk(16'(r), 16'h005A);
        @(posedge ref_clk) begin
            spin <= 1'b1;
            user_scan <= 1'b1;
            bar_edge_in <= 1'b1;
        end
        repeat (300) @(posedge ref_clk);
        chk(16'(laser_emitter), 16'h0001);
        chk(16'(motor_on), 16'h0001);
        chk(16'(digitized_pattern), 16'h0001);
        for (n = 0; n < 200 && scan_line_frame === motor_swing; n++)
            @(negedge ref_clk);
        chk(16'(n < 200), 16'h0001);
        @(negedge ref_clk);
        chk(16'(scan_line_frame), 16'(motor_swing));
        @(posedge ref_clk) user_scan <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk(16'(laser_emitter), 16'h0000);
        // Aim request alone also runs the beam
        @(posedge ref_clk) user_aim <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk(16'(laser_emitter), 16'h0001);
        @(posedge ref_clk) begin
            user_scan <= 1'b1;
            user_aim <= 1'b0;
            spin <= 1'b0;
        end
        repeat (4100) @(posedge ref_clk);
        chk(16'(laser_emitter), 16'h0000);
        chk(16'(motor_on), 16'h0001);
        @(posedge ref_clk) begin
            user_scan <= 1'b0;
            beep_req <= 1'b1;
        end
        count_beep(1'b1);
        count_beep(1'b0);
        chk(16'(n), 16'(BEEP_HALF_CYC));
        count_beep(1'b1);
        chk(16'(n), 16'(BEEP_HALF_CYC));
        @(negedge ref_clk);
        chk(16'(beep_seen), 16'h0001);
        @(posedge ref_clk) begin
            beep_req <= 1'b0;
            supply_low <= 1'b1;
        end
        repeat (3) @(posedge ref_clk);
        chk(16'(ctrl_ready), 16'h0000);
        @(posedge ref_clk) supply_low <= 1'b0;
        wait_ready();
        chk(16'(ctrl_ready), 16'h0001);
        @(posedge ref_clk) arst_n <= 1'b0;
        nv_mem[3] = 16'h0000;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        wait_ready();
        repeat (2) @(posedge ref_clk);
        chk(16'(nv_fault), 16'h0001);
        chk(nv_mem[0], DEF_BAUD);
        chk(nv_mem[1], DEF_FRAME);
        chk(nv_mem[3], NV_CHECK_GOOD);
        repeat (50) @(posedge ref_clk);
        chk(16'(nv_fault), 16'h0001);
        @(posedge ref_clk) repair_req <= 1'b1;
        @(posedge ref_clk) repair_req <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk(16'(nv_fault), 16'h0000);
        // Stored frame word asks for two stop bits
        @(posedge ref_clk) arst_n <= 1'b0;
        nv_mem[0] = 16'h0003;
        nv_mem[1] = 16'h0003;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        wait_ready();
        fork
            begin
                push(8'h81);
                push(8'h7E);
            end
            begin
                recv(r);
                chk(16'(r), 16'h0081);
                repeat (4) @(negedge ref_clk);
                chk(16'(sce_link_if_i.txd), 16'h0001);
                recv(r);
                chk(16'(r), 16'h007E);
            end
        join
        finish_test();
    end
endmodule

//--- verilog/sce_device.sv
// How it works
// - Hold controller in reset 70 ms.
// - Supply dropout below 2.8 V resets.
// - After reset check store, copy good parameters.
// - Faulty store gets defaults in RAM and store.
// - Fault flag cleared only on host request; code also clears it when a later store check passes.
// - Watchdog handled internally, never host configured.
// - Motor failure forces laser emitter off.
// - Frame signal toggles at scan line edges.
// - Scan request active low; ground starts scan.
// - Serial data leaves on TxD.
// - Host drives RxD from its transmitter.
// - With handshake, wait for CTS before sending.
// - With handshake, RTS shows data waiting.
// - RTS and CTS used only together.
// - Beeper 2.5 kHz square, half duty.
// - Aim left high during normal scanning.
// - Scan, motor, laser follow host inputs.
// - Pattern pulses track bar and space widths.
module sce_device
    import sce_pkg::*;
#(
    parameter int RESET_HOLD = RESET_HOLD_CYC
)(
    input wire logic ref_clk,
    input wire logic arst_n,
    sce_link_if.dev link,
    input wire logic supply_low,
    input wire logic motor_swing,
    input wire logic bar_edge_in,
    input wire logic beep_req,
    input wire logic repair_req,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [15:0] nv_wdata,
    output logic [1:0] nv_addr,
    output logic nv_we,
    input wire logic [15:0] nv_rdata,
    output logic ctrl_ready,
    output logic nv_fault,
    output logic wdog_bite,
    output logic motor_on,
    output logic laser_emitter,
    output logic scan_line_frame,
    output logic digitized_pattern
);
    import sce_pkg::*;

    logic [CNT_W-1:0] hold_reg;
    sce_init_t init_reg;
    logic [1:0] idx_reg;
    logic fault_reg;
    logic [DIV_W-1:0] baud_reg;
    logic [15:0] frame_reg;
    logic [2:0] s1_reg, s2_reg;
    logic [CNT_W-1:0] wd_reg, motor_reg, beep_reg;
    logic beep_lvl_reg, frame_reg_q, pat_reg, swing_q;
    // Two-entry buffer
    logic [7:0] buf_mem [2];
    logic wp_reg, rp_reg;
    logic [1:0] cnt_reg;
    // Transmitter
    sce_tx_t tx_reg;
    logic [9:0] sh_reg;
    logic [BITS_W-1:0] bit_reg;
    logic [DIV_W-1:0] div_reg;
    logic txd_reg, rts_reg;

    wire run = (init_reg == SCE_RUN);
    wire trig = ~s2_reg[0];
    wire aim = ~s2_reg[1];
    wire hs_on = frame_reg[FRAME_BIT_HS];
    wire cts_ok = ~hs_on | ~s2_reg[2];
    wire motor_ok = (motor_reg != '0);
    wire buf_push = tx_valid & tx_ready;
    wire buf_pop = (tx_reg == SCE_TX_WAIT) & cts_ok & (cnt_reg != 2'd0);
    wire [BITS_W-1:0] n_bits = frame_reg[FRAME_BIT_TWO_STOP] ?
        FRAME_BITS_TWO : FRAME_BITS_ONE;
    wire swing_edge = motor_swing ^ swing_q;
    wire check_ok = (nv_rdata == NV_CHECK_GOOD);
    wire [15:0] def_word = (idx_reg == 2'(NV_IDX_BAUD)) ? DEF_BAUD :
        (idx_reg == 2'(NV_IDX_FRAME)) ? DEF_FRAME :
        (idx_reg == 2'(NV_IDX_CHECK)) ? NV_CHECK_GOOD : DEF_SPARE;

    // Power-on and dropout hold counter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_reg <= CNT_W'(RESET_HOLD);
        end else if (supply_low) begin
            hold_reg <= CNT_W'(RESET_HOLD);
        end else begin
            hold_reg <= sce_dec(hold_reg);
        end
    end

    // Parameter store check, copy and default load
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            init_reg <= SCE_HOLD;
            idx_reg <= 2'd0;
            fault_reg <= 1'b0;
            baud_reg <= DIV_W'(BAUD_DIV_DEFAULT);
            frame_reg <= DEF_FRAME;
        end else if (supply_low || hold_reg != '0) begin
            init_reg <= SCE_HOLD;
            idx_reg <= 2'd0;
        end else begin
            case (init_reg)
                SCE_HOLD: begin
                    init_reg <= SCE_CHECK;
                    idx_reg <= 2'(NV_IDX_CHECK);
                end
                SCE_CHECK: begin
                    idx_reg <= 2'd0;
                    fault_reg <= ~check_ok;
                    init_reg <= check_ok ? SCE_COPY : SCE_DEFAULT;
                end
                SCE_COPY: begin
                    if (idx_reg == 2'(NV_IDX_BAUD)) begin
                        baud_reg <= nv_rdata;
                    end
                    if (idx_reg == 2'(NV_IDX_FRAME)) begin
                        frame_reg <= nv_rdata;
                    end
                    idx_reg <= idx_reg + 2'd1;
                    if (idx_reg == 2'(NV_WORDS - 1)) begin
                        init_reg <= SCE_RUN;
                    end
                end
                SCE_DEFAULT: begin
                    baud_reg <= DEF_BAUD;
                    frame_reg <= DEF_FRAME;
                    idx_reg <= idx_reg + 2'd1;
                    if (idx_reg == 2'(NV_WORDS - 1)) begin
                        init_reg <= SCE_RUN;
                    end
                end
                default: begin
                    // Repair only when asked
                    if (repair_req && fault_reg) begin
                        init_reg <= SCE_DEFAULT;
                        idx_reg <= 2'd0;
                        fault_reg <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign nv_addr = idx_reg;
    assign nv_wdata = def_word;
    assign nv_we = (init_reg == SCE_DEFAULT);
    assign ctrl_ready = run;
    assign nv_fault = fault_reg;

    // Input synchronisers: trigger, aim, clear-to-send
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= 3'h7;
            s2_reg <= 3'h7;
        end else begin
            s1_reg <= {link.cts_n, link.aim_n, link.scan_req_n};
            s2_reg <= s1_reg;
        end
    end

    // Internal watchdog, counts only while shifting a bit, reloaded at each bit end and whenever not running
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wd_reg <= CNT_W'(WDOG_CYC);
            wdog_bite <= 1'b0;
        end else if (!run || tx_reg != SCE_TX_SHIFT || div_reg == '0) begin
            wd_reg <= CNT_W'(WDOG_CYC);
            wdog_bite <= 1'b0;
        end else begin
            wd_reg <= sce_dec(wd_reg);
            wdog_bite <= (wd_reg == CNT_W'(1));
        end
    end

    // Motor supervision, scan line framing and pattern
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            motor_reg <= '0;
            swing_q <= 1'b0;
            frame_reg_q <= 1'b0; // Matches swing_q, no false edge
            pat_reg <= 1'b0;
        end else begin
            swing_q <= motor_swing;
            motor_reg <= swing_edge ? CNT_W'(MOTOR_TIMEOUT_CYC) :
                sce_dec(motor_reg);
            frame_reg_q <= motor_swing;
            pat_reg <= bar_edge_in & laser_emitter;
        end
    end

    assign motor_on = run & (trig | aim);
    assign laser_emitter = motor_on & motor_ok;
    assign scan_line_frame = frame_reg_q;
    assign digitized_pattern = pat_reg;

    // Beeper square wave, half period counter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            beep_reg <= '0;
            beep_lvl_reg <= 1'b0;
        end else if (!beep_req || !run) begin
            beep_reg <= '0;
            beep_lvl_reg <= 1'b0;
        end else if (beep_reg == '0) begin
            beep_reg <= CNT_W'(BEEP_HALF_CYC - 1);
            beep_lvl_reg <= ~beep_lvl_reg;
        end else begin
            beep_reg <= beep_reg - CNT_W'(1);
        end
    end

    assign link.beeper_n_o = 1'b0;
    assign link.beeper_n_oe = beep_lvl_reg;

    // Two-entry buffer in front of the transmitter
    assign tx_ready = run & (cnt_reg != 2'd2);
    always_ff @(posedge ref_clk) begin
        if (buf_push) begin
            buf_mem[wp_reg] <= tx_data;
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            cnt_reg <= 2'd0;
        end else begin
            wp_reg <= wp_reg ^ buf_push;
            rp_reg <= rp_reg ^ buf_pop;
            cnt_reg <= cnt_reg + 2'(buf_push) - 2'(buf_pop);
        end
    end

    // Serial transmitter, start bit, 8 data bits LSB first, stop
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_reg <= SCE_TX_IDLE;
            sh_reg <= '1;
            bit_reg <= '0;
            div_reg <= '0;
            txd_reg <= 1'b1;
            rts_reg <= 1'b0;
        end else begin
            case (tx_reg)
                SCE_TX_IDLE: begin
                    txd_reg <= 1'b1;
                    rts_reg <= 1'b0;
                    if (run && cnt_reg != 2'd0) begin
                        tx_reg <= SCE_TX_WAIT;
                    end
                end
                SCE_TX_WAIT: begin
                    rts_reg <= hs_on;
                    if (cnt_reg == 2'd0) begin
                        tx_reg <= SCE_TX_IDLE;
                    end else if (cts_ok) begin
                        sh_reg <= {1'b1, buf_mem[rp_reg], 1'b0};
                        bit_reg <= n_bits;
                        div_reg <= baud_reg;
                        tx_reg <= SCE_TX_SHIFT;
                    end
                end
                default: begin
                    txd_reg <= sh_reg[0];
                    if (div_reg != '0) begin
                        div_reg <= div_reg - DIV_W'(1);
                    end else begin
                        div_reg <= baud_reg;
                        sh_reg <= {1'b1, sh_reg[9:1]};
                        bit_reg <= bit_reg - BITS_W'(1);
                        if (bit_reg == BITS_W'(1)) begin
                            tx_reg <= SCE_TX_WAIT;
                        end
                    end
                end
            endcase
        end
    end

    assign link.txd = txd_reg;
    assign link.rts = rts_reg;
endmodule

//--- verilog/sce_host.sv
module sce_host
    import sce_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    sce_link_if.host link,
    input wire logic user_scan,
    input wire logic user_aim,
    input wire logic user_hs_en,
    input wire logic user_ready,
    input wire logic user_txd,
    output logic rts_seen,
    output logic beep_seen,
    output logic txd_seen
);
    import sce_pkg::*;
    logic scan_reg, aim_reg, cts_reg;
    logic rts_reg, beep_reg, txd_reg;

    // Request lines driven from flip-flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            scan_reg <= 1'b0;
            aim_reg <= 1'b0;
            cts_reg <= 1'b0;
        end else begin
            scan_reg <= user_scan;
            aim_reg <= user_aim;
            cts_reg <= user_hs_en & user_ready;
        end
    end

    // Sample what the device drives
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rts_reg <= 1'b0;
            beep_reg <= 1'b0;
            txd_reg <= 1'b1;
        end else begin
            rts_reg <= link.rts;
            beep_reg <= ~link.beeper_n;
            txd_reg <= link.txd;
        end
    end

    assign link.scan_req_n = ~scan_reg;
    assign link.aim_n = ~aim_reg;
    assign link.cts_n = ~cts_reg;
    assign link.rxd = user_txd;
    assign rts_seen = rts_reg;
    assign beep_seen = beep_reg;
    assign txd_seen = txd_reg;
endmodule

//--- verilog/sce_link_if.sv
interface sce_link_if;
    logic scan_req_n;      // Trigger, active low
    logic aim_n;           // Aim, active low
    logic txd;             // Device to host serial
    logic rxd;             // Host to device serial
    logic cts_n;           // Host permits sending
    logic rts;             // Device has data
    logic beeper_n_o;      // Open collector pull-down, low while active
    logic beeper_n_oe;
    logic beeper_n;        // Resolved wire level
    assign beeper_n = beeper_n_oe ? beeper_n_o : 1'b1;
    modport dev(input scan_req_n, aim_n, rxd, cts_n,
        output txd, rts, beeper_n_o, beeper_n_oe);
    modport host(output scan_req_n, aim_n, rxd, cts_n,
        input txd, rts, beeper_n);
endinterface

//--- verilog/sce_pkg.sv
package sce_pkg;
    // Clock and timing
    localparam int CLK_HZ = 100_000_000;
    localparam int RESET_HOLD_MS = 70;
    localparam int RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);
    localparam int BEEP_HZ = 2500;
    localparam int BEEP_HALF_CYC = CLK_HZ / (2 * BEEP_HZ);
    localparam int WDOG_CYC = 1024;
    localparam int MOTOR_TIMEOUT_CYC = 4000;
    localparam int BAUD_DIV_DEFAULT = 868;
    // Parameter store layout
    localparam int NV_WORDS = 4;
    localparam int NV_IDX_BAUD = 0;
    localparam int NV_IDX_FRAME = 1;
    localparam int NV_IDX_CHECK = 3;
    localparam logic [15:0] NV_CHECK_GOOD = 16'hA55A;
    localparam logic [15:0] DEF_BAUD = 16'h0364;
    localparam logic [15:0] DEF_FRAME = 16'h0001;
    localparam logic [15:0] DEF_SPARE = 16'h0000;
    localparam int FRAME_BIT_HS = 0;
    localparam int FRAME_BIT_TWO_STOP = 1;
    localparam int CNT_W = 24;
    localparam int DIV_W = 16;
    localparam int BITS_W = 4;
    localparam logic [BITS_W-1:0] FRAME_BITS_ONE = 4'hA;
    localparam logic [BITS_W-1:0] FRAME_BITS_TWO = 4'hB;

    typedef enum {
        SCE_HOLD, SCE_CHECK, SCE_COPY, SCE_DEFAULT, SCE_RUN
    } sce_init_t;
    typedef enum {SCE_TX_IDLE, SCE_TX_WAIT, SCE_TX_SHIFT} sce_tx_t;

    // Saturating decrement used by several counters
    function automatic logic [CNT_W-1:0] sce_dec(input logic [CNT_W-1:0] v);
        return (v == '0) ? '0 : v - 1'b1;
    endfunction
endpackage
